// ===== rtc_calendar_control.sv
// The address-and-strobe port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ns
`include "rtc_defs.svh"
module rtc_calendar_control (
  input wire logic mclk_in,
  input wire logic nrst_in,
  input wire rtc_pkg::rtc_addr_t addr_in,
  input wire rtc_pkg::rtc_word_t wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output rtc_pkg::rtc_word_t rdata_out,
  input wire logic secondary_oscillator_in,
  input wire logic low_power_rc_osc_in,
  input wire logic pwrl_in,
  output logic clk_pin_out,
  output logic clk_pin_oe_out
);
  import rtc_pkg::*;

  function automatic logic rtc_hit(input rtc_addr_t a, input rtc_addr_t o);
    return a == o;
  endfunction

  // carry in bit 4, next digit below; the digit restarts at zero
  function automatic logic [4:0] step4(input logic [3:0] v, input logic [3:0] last);
    return (v >= last) ? 5'h10 : {1'b0, v + 4'h1};
  endfunction

  function automatic logic [32:0] next_time(input rtc_word_t t);
    logic [32:0] r;
    logic [4:0] s;
    logic [3:0] hl;
    r = {1'b0, t};
    hl = ({1'b0, t[`RTC_T_HT]} == `RTC_BCD2) ? `RTC_BCD3 : `RTC_BCD9;
    s = step4(t[`RTC_T_SU], `RTC_BCD9);
    r[`RTC_T_SU] = s[3:0];
    if (s[4])
    begin
      s = step4(t[`RTC_T_ST], `RTC_BCD5);
      r[`RTC_T_ST] = s[3:0];
    end
    if (s[4])
    begin
      s = step4(t[`RTC_T_MU], `RTC_BCD9);
      r[`RTC_T_MU] = s[3:0];
    end
    if (s[4])
    begin
      s = step4({1'b0, t[`RTC_T_MT]}, `RTC_BCD5);
      r[`RTC_T_MT] = s[2:0];
    end
    if (s[4])
    begin
      s = step4(t[`RTC_T_HU], hl);
      r[`RTC_T_HU] = s[3:0];
    end
    if (s[4])
    begin
      s = step4({1'b0, t[`RTC_T_HT]}, `RTC_BCD2);
      r[`RTC_T_HT] = s[2:0];
    end
    r[32] = s[4];
    return r;
  endfunction

  // no year is kept, so February always ends on the 28th
  function automatic logic [5:0] month_last(input logic [4:0] m);
    case (m)
      5'h02: return 6'h28;
      5'h04, 5'h06, 5'h09, 5'h11: return 6'h30;
      default: return 6'h31;
    endcase
  endfunction

  function automatic rtc_word_t next_date(input rtc_word_t d);
    rtc_word_t r;
    logic [4:0] s;
    r = d;
    r[`RTC_D_WD] = (d[`RTC_D_WD] >= `RTC_WD_LAST) ? 3'h0 : d[`RTC_D_WD] + 3'h1;
    if ({d[`RTC_D_DT], d[`RTC_D_DU]} >= month_last({d[`RTC_D_MT], d[`RTC_D_MU]}))
    begin
      r[`RTC_D_DT] = 2'h0;
      r[`RTC_D_DU] = 4'h1;
      if ({d[`RTC_D_MT], d[`RTC_D_MU]} >= `RTC_MON_LAST)
        {r[`RTC_D_MT], r[`RTC_D_MU]} = `RTC_MON_FIRST;
      else
      begin
        s = step4(d[`RTC_D_MU], `RTC_BCD9);
        r[`RTC_D_MU] = s[3:0];
        r[`RTC_D_MT] = d[`RTC_D_MT] | s[4];
      end
    end
    else
    begin
      s = step4(d[`RTC_D_DU], `RTC_BCD9);
      r[`RTC_D_DU] = s[3:0];
      r[`RTC_D_DT] = d[`RTC_D_DT] + {1'b0, s[4]};
    end
    return r;
  endfunction

  // eq: 0 sec units, 1 sec tens, 2 min units, 3 min tens, 4 hours,
  // 5 weekday, 6 day, 7 month
  function automatic logic alarm_match(input logic [3:0] iv, input logic [7:0] eq);
    case (iv)
      `RTC_IV_HALF, `RTC_IV_SEC: return 1'b1;
      `RTC_IV_TSEC: return eq[0];
      `RTC_IV_MIN: return &eq[1:0];
      `RTC_IV_TMIN: return &eq[2:0];
      `RTC_IV_HOUR: return &eq[3:0];
      `RTC_IV_DAY: return &eq[4:0];
      `RTC_IV_WEEK: return &eq[5:0];
      `RTC_IV_MON: return &eq[4:0] && eq[6];
      `RTC_IV_YEAR: return &eq[4:0] && &eq[7:6];
      default: return 1'b0;
    endcase
  endfunction

  rtc_div_if dif ();
  rtc_divider #(.CNT_W(16)) u_div (
    .clk_in(mclk_in),
    .nrst_in(nrst_in),
    .dif(dif.div)
  );

  logic [2:0] s1_q;
  logic [2:0] s2_q;
  logic [2:0] s3_q;
  rtc_word_t con1_q;
  rtc_word_t con2_q;
  rtc_word_t time_q;
  rtc_word_t date_q;
  rtc_word_t atime_q;
  rtc_word_t adate_q;
  rtc_word_t rdata_q;
  logic evt_q;
  logic chk_q;
  logic pin_q;
  logic pin_oe_q;

  wire [2:0] pin_raw = {pwrl_in, low_power_rc_osc_in, secondary_oscillator_in};
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_sync
      always_ff @(posedge mclk_in or negedge nrst_in)
      begin
        if (!nrst_in)
        begin
          s1_q[gi] <= 1'b0;
          s2_q[gi] <= 1'b0;
          s3_q[gi] <= 1'b0;
        end
        else
        begin
          s1_q[gi] <= pin_raw[gi];
          s2_q[gi] <= s1_q[gi];
          s3_q[gi] <= s2_q[gi];
        end
      end
    end
  endgenerate

  // slow sources count on their rising edge; the peripheral clock every cycle
  wire [2:0] pin_edge = s2_q & ~s3_q;
  wire [1:0] src = con2_q[`RTC_C2_SRC];
  wire src_tick = (src == `RTC_SRC_PERIPH) ? 1'b1 : // R8
    (src == `RTC_SRC_PWRL) ? pin_edge[2] : (src == `RTC_SRC_LOW_POWER_RC_OSC) ? pin_edge[1] : pin_edge[0];
  wire on = con1_q[`RTC_C1_ON];
  assign dif.base_tick = on && src_tick; // R16
  assign dif.prescale = con2_q[`RTC_C2_PS];
  assign dif.period = con2_q[`RTC_C2_DIV]; // R5
  assign dif.trim = con2_q[`RTC_C2_TRIM];
  wire sec_tick = dif.sec_tick;

  wire lock = con1_q[`RTC_C1_LOCK];
  wire wr_con1 = wr_in && rtc_hit(addr_in, `RTC_OFS_CON1);
  wire wr_con2 = wr_in && rtc_hit(addr_in, `RTC_OFS_CON2) && !lock; // R1
  wire wr_time = wr_in && rtc_hit(addr_in, `RTC_OFS_TIME) && !lock; // R1
  wire wr_date = wr_in && rtc_hit(addr_in, `RTC_OFS_DATE) && !lock; // R1
  wire wr_atime = wr_in && rtc_hit(addr_in, `RTC_OFS_ATIME);
  wire wr_adate = wr_in && rtc_hit(addr_in, `RTC_OFS_ADATE);
  wire rd_stat = rd_in && rtc_hit(addr_in, `RTC_OFS_STAT);

  wire [32:0] tn = next_time(time_q); // R19
  wire rtc_word_t time_d = wr_time ? (wdata_in & `RTC_TM_WMASK) : // R13
    (sec_tick ? tn[31:0] : time_q);
  wire rtc_word_t date_d = wr_date ? (wdata_in & `RTC_DT_WMASK) : // R15
    ((sec_tick && tn[32]) ? next_date(date_q) : date_q); // R19

  wire [3:0] ival = con1_q[`RTC_C1_IVAL];
  wire alm_en = con1_q[`RTC_C1_ALMEN];
  wire chime = con1_q[`RTC_C1_CHIME];
  wire [7:0] rpt = con1_q[`RTC_C1_RPT];
  // compare one cycle after the tick, against the already advanced time
  wire chk_d = sec_tick || (dif.half_tick && ival == `RTC_IV_HALF); // R17
  wire [7:0] eq = {
    date_q[`RTC_D_MT] == adate_q[`RTC_D_MT] && date_q[`RTC_D_MU] == adate_q[`RTC_D_MU],
    date_q[`RTC_D_DT] == adate_q[`RTC_D_DT] && date_q[`RTC_D_DU] == adate_q[`RTC_D_DU],
    date_q[`RTC_D_WD] == adate_q[`RTC_D_WD],
    time_q[`RTC_T_HT] == atime_q[`RTC_T_HT] && time_q[`RTC_T_HU] == atime_q[`RTC_T_HU],
    time_q[`RTC_T_MT] == atime_q[`RTC_T_MT],
    time_q[`RTC_T_MU] == atime_q[`RTC_T_MU],
    time_q[`RTC_T_ST] == atime_q[`RTC_T_ST],
    time_q[`RTC_T_SU] == atime_q[`RTC_T_SU]};
  wire evt = chk_q && alm_en && alarm_match(ival, eq); // R18 R20

  wire rpt_zero = rpt == `RTC_RPT_MIN;
  wire [7:0] rpt_nx = rpt_zero ? (chime ? `RTC_RPT_MAX : rpt) : rpt - 8'h01; // R4
  wire en_nx = !(rpt_zero && !chime);
  wire rtc_word_t con1_w = wr_con1 ? (wdata_in & `RTC_C1_WMASK) : con1_q; // R14
  // the hardware update of enable and count wins over a same-cycle write
  wire rtc_word_t con1_d = evt ?
    ((con1_w & ~`RTC_C1_HWMASK) | {en_nx, 7'h00, rpt_nx, 16'h0000}) : con1_w; // R4
  wire rtc_word_t con2_d = wr_con2 ? (wdata_in & `RTC_C2_WMASK) : con2_q; // R14

  wire sync = on && dif.near_end; // R10
  wire alarm_write_unsafe = sync && alm_en; // R11
  wire rtc_word_t stat_w = {26'h0, evt_q, 2'b00, sync, alarm_write_unsafe, dif.second_half}; // R12
  wire rtc_word_t rd_mux = rtc_hit(addr_in, `RTC_OFS_CON1) ? con1_q :
    rtc_hit(addr_in, `RTC_OFS_CON2) ? con2_q :
    rtc_hit(addr_in, `RTC_OFS_STAT) ? stat_w :
    rtc_hit(addr_in, `RTC_OFS_TIME) ? time_q :
    rtc_hit(addr_in, `RTC_OFS_DATE) ? date_q :
    rtc_hit(addr_in, `RTC_OFS_ATIME) ? atime_q :
    rtc_hit(addr_in, `RTC_OFS_ADATE) ? adate_q : `RTC_ZERO;
  wire rtc_word_t rdata_d = rd_in ? rd_mux : `RTC_ZERO;

  wire [2:0] osel = con1_q[`RTC_C1_OSEL];
  wire oe = con1_q[`RTC_C1_OE];
  wire pin_sel = (osel == `RTC_OSEL_ALARM) ? evt : // R3
    (osel == `RTC_OSEL_SEC) ? dif.second_half :
    (osel == `RTC_OSEL_DCLK) ? dif.div_clk : 1'b0;

  always_ff @(posedge mclk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      con1_q <= `RTC_ZERO;
      con2_q <= `RTC_ZERO;
      time_q <= `RTC_ZERO;
      date_q <= `RTC_ZERO;
    end
    else
    begin
      con1_q <= con1_d;
      con2_q <= con2_d;
      time_q <= time_d;
      date_q <= date_d;
    end
  end

  always_ff @(posedge mclk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      atime_q <= `RTC_ZERO;
      adate_q <= `RTC_ZERO;
      chk_q <= 1'b0;
      evt_q <= 1'b0;
    end
    else
    begin
      atime_q <= wr_atime ? (wdata_in & `RTC_TM_WMASK) : atime_q;
      adate_q <= wr_adate ? (wdata_in & `RTC_DT_WMASK) : adate_q;
      chk_q <= chk_d;
      // a new event beats the clear that the status read brings
      evt_q <= evt || (evt_q && !rd_stat); // R9
    end
  end

  always_ff @(posedge mclk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      rdata_q <= `RTC_ZERO;
      pin_q <= 1'b0;
      pin_oe_q <= 1'b0;
    end
    else
    begin
      rdata_q <= rdata_d;
      pin_q <= oe && pin_sel; // R2
      pin_oe_q <= oe; // R2
    end
  end

  assign rdata_out = rdata_q;
  assign clk_pin_out = pin_q;
  assign clk_pin_oe_out = pin_oe_q;

  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!nrst_in);

  a_lock_blocks_time: // R1
    assert property (wr_in && addr_in == `RTC_OFS_TIME && lock && !sec_tick
      |=> time_q == $past(time_q))
    else $error("locked time register changed on write");

  a_time_write_load: // R1
    assert property (wr_in && addr_in == `RTC_OFS_TIME && !lock
      |=> time_q == ($past(wdata_in) & `RTC_TM_WMASK))
    else $error("unlocked time write not loaded");

  a_pin_disabled: // R2
    assert property (!oe |=> !clk_pin_oe_out && !clk_pin_out)
    else $error("pin driven while output disabled");

  a_pin_sec_sel: // R3
    assert property (oe && osel == `RTC_OSEL_SEC
      |=> clk_pin_out == $past(dif.second_half))
    else $error("pin does not follow seconds clock");

  a_rpt_decrement: // R4
    assert property (evt && !rpt_zero && !wr_con1 |=> rpt == $past(rpt) - 8'h01)
    else $error("repeat count did not decrement");

  a_rpt_stop_zero: // R4
    assert property (evt && rpt_zero && !chime
      |=> rpt == `RTC_RPT_MIN && !alm_en)
    else $error("repeat count left zero without chime");

  a_evt_flag_set: // R9
    assert property (evt |=> evt_q ##1 (evt_q || $past(rd_stat)))
    else $error("alarm flag not set by event");

  a_sync_readback: // R10
    assert property (rd_stat |=> rdata_out[`RTC_ST_SYNC] == $past(sync))
    else $error("read-unsafe status wrong");

  a_off_no_tick: // R16
    assert property (!on && !wr_time |=> time_q == $past(time_q))
    else $error("time advanced while disabled");

  a_alarm_needs_en: // R18
    assert property (!alm_en |=> !evt_q || $past(evt_q))
    else $error("alarm flag set while alarm disabled");

  a_sec_advance: // R19
    assert property (sec_tick && !wr_time && time_q[`RTC_T_SU] < `RTC_BCD9
      |=> time_q[`RTC_T_SU] == $past(time_q[`RTC_T_SU]) + 4'h1)
    else $error("seconds did not advance");

  a_rsvd_zero: // R14
    assert property (rd_in && addr_in == `RTC_OFS_CON1
      |=> (rdata_out & ~`RTC_C1_WMASK) == `RTC_ZERO)
    else $error("unimplemented bits read nonzero");
endmodule // rtc_calendar_control

// ===== rtc_defs.svh
`ifndef RTC_DEFS_SVH
`define RTC_DEFS_SVH
// Notes on behaviour
// R1: write lock blocks timekeeping register writes
// R2: output enable drives selected signal to pin
// R3: select 000 alarm, 001 seconds, 010 divided
// R4: repeat count decrements; wraps only with chime
// R5: sixteen-bit divide field sets seconds period
// R6: trim adds N input cycles every 16s
// R7: prescale 256, 64, 16 or 1
// R8: source select picks the counting timebase
// R9: alarm flag set and cleared by hardware
// R10: read-unsafe flag while time may change
// R11: alarm writes unsafe while alarm-sync flag set
// R12: half flag marks second half of second
// R13: time fields are packed BCD digits
// R14: unimplemented bits read zero, ignore writes
// R15: date fields are packed BCD digits
// R16: counting only while enable bit set
// R17: interval field selects alarm repeat period
// R18: alarm events only while alarm enabled
// R19: seconds tick advances time, date, weekday
// R20: alarm fires on unmasked field match
`define RTC_OFS_CON1 8'h00
`define RTC_OFS_CON2 8'h10
`define RTC_OFS_STAT 8'h30
`define RTC_OFS_TIME 8'h40
`define RTC_OFS_DATE 8'h50
`define RTC_OFS_ATIME 8'h60
`define RTC_OFS_ADATE 8'h70
`define RTC_ZERO 32'h00000000
`define RTC_C1_WMASK 32'hcfff88f0
`define RTC_C1_HWMASK 32'h80ff0000
`define RTC_C2_WMASK 32'hfffff833
`define RTC_TM_WMASK 32'h7f7fff00
`define RTC_DT_WMASK 32'h001f3f07
`define RTC_C1_ALMEN 31
`define RTC_C1_CHIME 30
`define RTC_C1_IVAL 27:24
`define RTC_C1_RPT 23:16
`define RTC_C1_ON 15
`define RTC_C1_LOCK 11
`define RTC_C1_OE 7
`define RTC_C1_OSEL 6:4
`define RTC_C2_DIV 31:16
`define RTC_C2_TRIM 15:11
`define RTC_C2_PS 5:4
`define RTC_C2_SRC 1:0
`define RTC_ST_SYNC 2
`define RTC_T_HT 30:28
`define RTC_T_HU 27:24
`define RTC_T_MT 22:20
`define RTC_T_MU 19:16
`define RTC_T_ST 15:12
`define RTC_T_SU 11:8
`define RTC_D_MT 20
`define RTC_D_MU 19:16
`define RTC_D_DT 13:12
`define RTC_D_DU 11:8
`define RTC_D_WD 2:0
`define RTC_OSEL_ALARM 3'h0
`define RTC_OSEL_SEC 3'h1
`define RTC_OSEL_DCLK 3'h2
`define RTC_PS_256 2'h3
`define RTC_PS_64 2'h2
`define RTC_PS_16 2'h1
`define RTC_PRE_256 8'hff
`define RTC_PRE_64 8'h3f
`define RTC_PRE_16 8'h0f
`define RTC_PRE_1 8'h00
`define RTC_SRC_PERIPH 2'h3
`define RTC_SRC_PWRL 2'h2
`define RTC_SRC_LOW_POWER_RC_OSC 2'h1
`define RTC_TRIM_SEC 4'hf
`define RTC_TRIM_NONE 5'h00
`define RTC_RPT_MIN 8'h00
`define RTC_RPT_MAX 8'hff
`define RTC_IV_HALF 4'h0
`define RTC_IV_SEC 4'h1
`define RTC_IV_TSEC 4'h2
`define RTC_IV_MIN 4'h3
`define RTC_IV_TMIN 4'h4
`define RTC_IV_HOUR 4'h5
`define RTC_IV_DAY 4'h6
`define RTC_IV_WEEK 4'h7
`define RTC_IV_MON 4'h8
`define RTC_IV_YEAR 4'h9
`define RTC_BCD9 4'h9
`define RTC_BCD5 4'h5
`define RTC_BCD3 4'h3
`define RTC_BCD2 4'h2
`define RTC_WD_LAST 3'h6
`define RTC_MON_LAST 5'h12
`define RTC_MON_FIRST 5'h01
`endif

// ===== rtc_div_if.sv
`timescale 1ns/1ns
interface rtc_div_if;
  logic base_tick;
  logic [1:0] prescale;
  logic [15:0] period;
  logic [4:0] trim;
  logic sec_tick;
  logic half_tick;
  logic second_half;
  logic near_end;
  logic div_clk;
  modport ctl (output base_tick, prescale, period, trim,
    input sec_tick, half_tick, second_half, near_end, div_clk);
  modport div (input base_tick, prescale, period, trim,
    output sec_tick, half_tick, second_half, near_end, div_clk);
endinterface // rtc_div_if

// ===== rtc_divider.sv
`timescale 1ns/1ns
`include "rtc_defs.svh"
module rtc_divider #(
  parameter int CNT_W = 16
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  rtc_div_if.div dif
);
  import rtc_pkg::*;
  generate
    if (CNT_W < 2 || CNT_W > 16)
    begin : g_bad
      $error("rtc_divider: CNT_W must be 2 to 16");
    end
  endgenerate
  rtc_div_state_e st_q;
  rtc_div_state_e st_d;
  logic [7:0] pre_q;
  logic [CNT_W-1:0] cnt_q;
  logic [3:0] secs_q;
  logic [4:0] trim_q;
  logic half_q;
  logic dclk_q;
  wire [1:0] ps = dif.prescale;
  wire [7:0] pre_last = (ps == `RTC_PS_256) ? `RTC_PRE_256 : // R7
    (ps == `RTC_PS_64) ? `RTC_PRE_64 : (ps == `RTC_PS_16) ? `RTC_PRE_16 : `RTC_PRE_1;
  wire run = st_q == RTC_RUN;
  wire [CNT_W-1:0] per = dif.period[CNT_W-1:0];
  // >= keeps the counters sane when software shrinks a field mid-count
  wire pre_end = run && dif.base_tick && pre_q >= pre_last;
  wire cnt_end = pre_end && cnt_q >= per; // R5
  wire do_trim = cnt_end && secs_q == `RTC_TRIM_SEC && dif.trim != `RTC_TRIM_NONE; // R6
  wire trim_end = !run && dif.base_tick && trim_q == dif.trim - 5'h01; // R6
  assign dif.sec_tick = (cnt_end && !do_trim) || trim_end;
  assign dif.half_tick = pre_end && cnt_q == (per >> 1);
  assign dif.second_half = half_q;
  assign dif.near_end = !run || cnt_q >= per;
  assign dif.div_clk = dclk_q;
  assign st_d = do_trim ? RTC_TRIM : (trim_end ? RTC_RUN : st_q);
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      st_q <= RTC_RUN;
      pre_q <= `RTC_PRE_1;
      cnt_q <= '0;
      trim_q <= `RTC_TRIM_NONE;
    end
    else
    begin
      st_q <= st_d;
      pre_q <= pre_end ? `RTC_PRE_1 : ((run && dif.base_tick) ? pre_q + 8'h01 : pre_q);
      cnt_q <= cnt_end ? '0 : (pre_end ? cnt_q + 1'b1 : cnt_q);
      trim_q <= run ? `RTC_TRIM_NONE : (dif.base_tick ? trim_q + 5'h01 : trim_q);
    end
  end
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      secs_q <= 4'h0;
      half_q <= 1'b0;
      dclk_q <= 1'b0;
    end
    else
    begin
      secs_q <= dif.sec_tick ? secs_q + 4'h1 : secs_q;
      half_q <= dif.sec_tick ? 1'b0 : (dif.half_tick ? 1'b1 : half_q); // R12
      dclk_q <= pre_end ? ~dclk_q : dclk_q;
    end
  end
endmodule // rtc_divider

// ===== rtc_pkg.sv
package rtc_pkg;
  typedef logic [7:0] rtc_addr_t;
  typedef logic [31:0] rtc_word_t;
  typedef enum logic [1:0] {RTC_RUN = 2'b01, RTC_TRIM = 2'b10} rtc_div_state_e;
endpackage : rtc_pkg

// ===== tb_top.sv
`timescale 1ns/1ns
`include "rtc_defs.svh"
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin fail_count++; \
  $display("Error t=%0t got %h exp %h", $time, g, e); end end
module tb_top;
  import rtc_pkg::*;
  logic mclk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic rd_d = 1'b0;
  logic secondary_oscillator_in = 1'b0;
  logic low_power_rc_osc_in = 1'b0;
  logic pwrl_in = 1'b0;
  logic clk_pin_out;
  logic clk_pin_oe_out;
  logic [2:0] ph = 3'h0;
  rtc_addr_t addr_in = 8'h00;
  rtc_word_t wdata_in = 32'h0;
  rtc_word_t rdata_out;
  rtc_word_t d;
  rtc_word_t r;
  rtc_word_t exp_q[$];
  rtc_word_t msk_q[$];
  integer seed = 32'heebed3fc;
  int fail_count = 0;
  int checked = 0;
  int src = 4;
  int n;
  int m;
  rtc_addr_t ofs[6] = '{8'h00, 8'h10, 8'h40, 8'h50, 8'h60, 8'h70};
  rtc_word_t msk[6] = '{`RTC_C1_WMASK, `RTC_C2_WMASK, `RTC_TM_WMASK, `RTC_DT_WMASK,
    `RTC_TM_WMASK, `RTC_DT_WMASK};
  int pre[4] = '{1, 16, 64, 256};
  int ivp[5] = '{2, 4, 40, 240, 2400};

  rtc_calendar_control i_dut (
    .mclk_in(mclk_in),
    .nrst_in(nrst_in),
    .addr_in(addr_in),
    .wdata_in(wdata_in),
    .wr_in(wr_in),
    .rd_in(rd_in),
    .rdata_out(rdata_out),
    .secondary_oscillator_in(secondary_oscillator_in),
    .low_power_rc_osc_in(low_power_rc_osc_in),
    .pwrl_in(pwrl_in),
    .clk_pin_out(clk_pin_out),
    .clk_pin_oe_out(clk_pin_oe_out)
  );

  initial
  begin
    forever #50 mclk_in = ~mclk_in;
  end

  // the selected source gets a clean square wave, the others noise, so a wrong pick shows
  always @(posedge mclk_in)
  begin
    r = $random(seed);
    ph <= ph + 3'h1;
    secondary_oscillator_in <= (src == 0) ? ph[2] : (src == 4) ? 1'b0 : r[0];
    low_power_rc_osc_in <= (src == 1) ? ph[2] : (src == 4) ? 1'b0 : r[1];
    pwrl_in <= (src == 2) ? ph[2] : (src == 4) ? 1'b0 : r[2];
  end

  always @(posedge mclk_in) rd_d <= rd_in;

  always @(negedge mclk_in)
  begin
    if (rd_d && exp_q.size() > 0)
    begin
      `CHK(rdata_out & msk_q[0], exp_q[0])
      void'(exp_q.pop_front());
      void'(msk_q.pop_front());
    end
  end

  task automatic tally_and_finish;
    if (fail_count == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic wr(rtc_addr_t a, rtc_word_t v);
    @(posedge mclk_in);
    wr_in <= 1'b1;
    addr_in <= a;
    wdata_in <= v;
    @(posedge mclk_in);
    wr_in <= 1'b0;
  endtask

  task automatic rd(rtc_addr_t a, rtc_word_t e, rtc_word_t mk = 32'hffffffff);
    exp_q.push_back(e & mk);
    msk_q.push_back(mk);
    @(posedge mclk_in);
    rd_in <= 1'b1;
    addr_in <= a;
    @(posedge mclk_in);
    rd_in <= 1'b0;
    @(posedge mclk_in);
  endtask

  task automatic pulses(int cyc, output int k);
    logic p;
    k = 0;
    p = clk_pin_out;
    repeat (cyc)
    begin
      @(negedge mclk_in);
      if (clk_pin_out === 1'b1 && p === 1'b0) k++;
      p = clk_pin_out;
    end
  endtask

  // skips the first whole period so a stale setting cannot leak into the count
  task automatic period(int np, int e);
    int c;
    int k;
    int t;
    logic p;
    c = 0;
    k = -2;
    t = 0;
    p = 1'b1;
    while (k < np)
    begin
      @(negedge mclk_in);
      t++;
      if (k >= 0) c++;
      if (clk_pin_out === 1'b1 && p === 1'b0) k++;
      p = clk_pin_out;
      if (t > 20000)
      begin
        fail_count++;
        tally_and_finish;
      end
    end
    `CHK(c, e)
  endtask

  task automatic wait_pin(logic v);
    int t;
    t = 0;
    while (clk_pin_out !== v)
    begin
      @(negedge mclk_in);
      t++;
      if (t > 20000)
      begin
        fail_count++;
        tally_and_finish;
      end
    end
  endtask

  initial
  begin
    repeat (2) @(posedge mclk_in);
    nrst_in <= 1'b1;
    @(negedge mclk_in);
    `CHK(clk_pin_oe_out, 1'b0)
    for (int i = 0; i < 6; i++) rd(ofs[i], 32'h0);
    rd(8'h30, 32'h0);
    for (int j = 0; j < 3; j++)
      for (int i = 0; i < 6; i++)
      begin
        d = $random(seed);
        d = (i == 0) ? (d & 32'hffff77ff) : d;
        wr(ofs[i], d);
        rd(ofs[i], d & msk[i]);
      end
    wr(8'h30, 32'hffffffff);
    rd(8'h30, 32'h0);
    wr(8'h20, 32'hffffffff);
    rd(8'h20, 32'h0);
    for (int i = 1; i < 4; i++) wr(ofs[i], 32'h0);
    wr(8'h00, 32'h00000800);
    for (int i = 1; i < 4; i++)
    begin
      wr(ofs[i], 32'hffffffff);
      rd(ofs[i], 32'h0);
    end
    wr(8'h00, 32'h0);
    for (int i = 1; i < 4; i++)
    begin
      wr(ofs[i], 32'hffffffff);
      rd(ofs[i], msk[i]);
    end
    for (int s = 0; s < 8; s++)
    begin
      wr(8'h00, 32'h80 | (s << 4));
      repeat (3) @(negedge mclk_in);
      `CHK(clk_pin_oe_out, 1'b1)
      `CHK(clk_pin_out, 1'b0)
    end
    for (int s = 0; s < 4; s++)
    begin
      src <= s;
      wr(8'h10, 32'h00010000 | s);
      wr(8'h00, 32'h00008090);
      period(2, (s == 3) ? 4 : 32);
    end
    for (int p = 0; p < 4; p++)
    begin
      wr(8'h10, 32'h00010003 | (p << 4));
      wr(8'h00, 32'h00008090);
      period(1, 2 * pre[p]);
      wr(8'h00, 32'h000080a0);
      period(1, 2 * pre[p]);
    end
    wr(8'h10, 32'h00012803);
    wr(8'h00, 32'h00008090);
    period(16, 37);
    wr(8'h00, 32'h00008010);
    repeat (8) @(negedge mclk_in);
    `CHK(clk_pin_oe_out, 1'b0)
    `CHK(clk_pin_out, 1'b0)
    wr(8'h00, 32'h000080b0);
    pulses(40, n);
    `CHK(n, 0)
    wr(8'h00, 32'h0);
    wr(8'h40, 32'h23595900);
    wr(8'h50, 32'h00123106);
    wr(8'h10, 32'h00030013);
    wr(8'h00, 32'h00008090);
    wait_pin(1'b1);
    wait_pin(1'b0);
    wr(8'h00, 32'h00000090);
    rd(8'h40, 32'h0);
    rd(8'h50, 32'h00010100);
    repeat (200) @(posedge mclk_in);
    rd(8'h40, 32'h0);
    wr(8'h10, 32'h00030003);
    wr(8'h00, 32'h81028080);
    pulses(100, n);
    `CHK(n, 3)
    rd(8'h00, 32'h01008080);
    rd(8'h30, 32'h20, 32'h20);
    rd(8'h30, 32'h0, 32'h20);
    wr(8'h00, 32'hc1018080);
    // the pin is watched without a gap while a write stops the source
    fork
      pulses(50, n);
      begin
        repeat (40) @(negedge mclk_in);
        src <= 4;
        wr(8'h10, 32'h00030000);
      end
    join
    pulses(10, m);
    rd(8'h00, {8'hc1, 8'h01 - 8'(n + m), 16'h8080});
    // a zero divide keeps the divider in its last period, so the read-unsafe flag stands, and the alarm one until the alarm is disabled
    wr(8'h10, 32'h00000000);
    rd(8'h30, 32'h6, 32'h6);
    wr(8'h00, 32'h00008000);
    rd(8'h30, 32'h4, 32'h6);
    // alarm time must hold legal digits or the ten-second and longer interval alarms never match
    wr(8'h60, 32'h00000000);
    src <= 3;
    wr(8'h10, 32'h00030003);
    for (int v = 0; v < 5; v++)
    begin
      wr(8'h00, {4'hc, 4'(v), 8'hff, 16'h8080});
      period(2, 2 * ivp[v]);
    end
    tally_and_finish;
  end
endmodule // tb_top
